// ---- brp_params.svh ----
`ifndef BRP_PARAMS_SVH
`define BRP_PARAMS_SVH

// ****************************************
// parameter addresses
// ****************************************
`define BRP_ADDR_BRAKE_RELEASE 16'h0814
`define BRP_ADDR_ABS_READBACK 16'h1E1E
`define BRP_ADDR_ABS_SET 16'h052C

// ****************************************
// values and reset values
// ****************************************
`define BRP_BRAKE_AUTO 16'h0000
`define BRP_BRAKE_MANUAL 16'h0001
`define BRP_BRAKE_RESET 16'h0000
`define BRP_WORD_ZERO 32'h0000_0000
`define BRP_HALF_ZERO 16'h0000
`define BRP_WARN_ABS_BIT 13

// ****************************************
// encoder range
// ****************************************
`define BRP_REV_BITS 14
`define BRP_TURN_BITS 12

// ****************************************
// timing
// ****************************************
`define BRP_CLK_FREQ_KHZ 10000
`define BRP_SAVE_WAIT_MS 1000

`endif

// ---- brp_pkg.sv ----
package brp_pkg;

  // drive state as reported by the drive state machine
  typedef enum logic [2:0] {
    brp_not_ready,
    brp_sw_on_disabled,
    brp_ready_sw_on,
    brp_switched_on,
    brp_op_enabled,
    brp_quick_stop,
    brp_fault_reaction,
    brp_fault
  } brp_drive_state_t;

  // state of the save hold-off sequence
  typedef enum logic {
    brp_save_idle,
    brp_save_hold
  } brp_save_state_t;

  // keep a position inside an encoder range of 2**bits user units
  function automatic logic [31:0] brp_wrap(input logic [31:0] pos, input logic [5:0] bits);
    logic [31:0] mask;
    mask = (32'h0000_0001 << bits) - 32'h0000_0001;
    return pos & mask;
  endfunction

endpackage

// ---- brp_abs_pos.sv ----
`timescale 1ns/100ps
`include "brp_params.svh"

module brp_abs_pos
  import brp_pkg::*;
#(
  parameter int REV_BITS = `BRP_REV_BITS,
  parameter int TURN_BITS = `BRP_TURN_BITS
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // encoder at start-up
  input wire logic enc_pos_valid_i,
  input wire logic [31:0] enc_pos_i,
  input wire logic enc_multiturn_i,
  input wire logic rotation_direction_invert_i,
  // result
  output logic captured_o,
  output logic [31:0] readback_o
);

  logic [5:0] range_bits;
  logic [31:0] oriented_pos;
  logic take;

  // [R07] range by encoder type
  assign range_bits = enc_multiturn_i ? 6'(REV_BITS + TURN_BITS) : 6'(REV_BITS);
  // [R11] direction inversion, before folding
  assign oriented_pos = rotation_direction_invert_i ? (`BRP_WORD_ZERO - enc_pos_i) : enc_pos_i;
  // only the first valid reading after power-up counts
  assign take = enc_pos_valid_i && !captured_o;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      captured_o <= 1'b0;
      readback_o <= `BRP_WORD_ZERO;
    end else if (take) begin
      captured_o <= 1'b1;
      readback_o <= brp_wrap(oriented_pos, range_bits);
    end
  end

endmodule // brp_abs_pos

// ---- brp_top.sv ----
`timescale 1ns/100ps
`include "brp_params.svh"

// Notes on behaviour
// [R01] The brake release setting holds 0 for automatic brake handling and 1 for manual opening.
// [R02] A manual release drives the brake output only in switch-on-disabled or ready-to-switch-on.
// [R03] The brake release setting is cleared to 0 whenever the power stage is active.
// [R04] The power stage may not be enabled while the brake is manually released.
// [R05] With the power stage on, the automatic controller owns the brake and a manual release errs.
// [R06] The absolute position is read from the encoder at start-up and shown read-only in usr.
// [R07] The reported range is one revolution for singleturn, the whole range for multiturn.
// [R08] Until the position is captured, warning bit 13 is set in latched and active words.
// [R09] A new absolute position is set at standstill and accepted with the power stage on or off.
// [R10] Setting a new absolute position moves the encoder and the simulation index pulses.
// [R11] Clockwise is seen from the shaft end and a direction-inversion setting corrects it.
// [R12] A new absolute position takes effect at next power-on, after at least 1 s before power-off.
module brp_top
  import brp_pkg::*;
#(
  parameter int REV_BITS = `BRP_REV_BITS,
  parameter int TURN_BITS = `BRP_TURN_BITS,
  parameter int SAVE_WAIT_CYCLES = `BRP_SAVE_WAIT_MS * `BRP_CLK_FREQ_KHZ
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // parameter access
  input wire logic [15:0] param_addr_i,
  input wire logic [31:0] param_wdata_i,
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  output logic [31:0] param_rdata_o,
  output logic param_ack_o,
  output logic param_err_o,
  // drive state and power stage
  input wire brp_drive_state_t drive_state_i,
  input wire logic power_stage_active_i,
  input wire logic enable_request_i,
  input wire logic standstill_i,
  output logic enable_grant_o,
  // brake
  input wire logic auto_brake_open_i,
  output logic brake_out_o,
  output logic brake_error_o,
  // encoder
  input wire logic enc_pos_valid_i,
  input wire logic [31:0] enc_pos_i,
  input wire logic enc_multiturn_i,
  input wire logic rotation_direction_invert_i,
  output logic [31:0] index_offset_o,
  output logic [31:0] esim_index_offset_o,
  output logic index_shift_o,
  // persistent store of the new absolute position
  output logic [31:0] abs_store_value_o,
  output logic abs_store_wr_o,
  output logic abs_store_busy_o,
  // warnings
  input wire logic warn_clear_i,
  output logic [15:0] warning_latched_word_o,
  output logic [15:0] warning_active_word_o
);

  localparam logic [23:0] SAVE_LAST = 24'(SAVE_WAIT_CYCLES - 1);

  // ****************************************
  // state
  // ****************************************
  logic [15:0] brake_release_select;
  logic [31:0] abs_set_value;
  brp_save_state_t save_state;
  brp_save_state_t next_save_state;
  logic [23:0] save_cnt;
  logic [23:0] next_save_cnt;
  logic abs_captured;
  logic [31:0] abs_readback;

  // ****************************************
  // absolute position capture
  // ****************************************
  // [R06] start-up position capture
  brp_abs_pos #(
    .REV_BITS(REV_BITS),
    .TURN_BITS(TURN_BITS)
  ) u_abs_pos (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .enc_pos_valid_i(enc_pos_valid_i),
    .enc_pos_i(enc_pos_i),
    .enc_multiturn_i(enc_multiturn_i),
    .rotation_direction_invert_i(rotation_direction_invert_i),
    .captured_o(abs_captured),
    .readback_o(abs_readback)
  );

  // ****************************************
  // decoding
  // ****************************************
  wire hit_brake = param_addr_i == `BRP_ADDR_BRAKE_RELEASE;
  wire hit_readback = param_addr_i == `BRP_ADDR_ABS_READBACK;
  wire hit_set = param_addr_i == `BRP_ADDR_ABS_SET;
  wire hit_any = hit_brake || hit_readback || hit_set;
  wire upper_zero = param_wdata_i[31:16] == `BRP_HALF_ZERO;
  wire val_auto = upper_zero && param_wdata_i[15:0] == `BRP_BRAKE_AUTO;
  wire val_manual = upper_zero && param_wdata_i[15:0] == `BRP_BRAKE_MANUAL;
  wire [5:0] range_bits = enc_multiturn_i ? 6'(REV_BITS + TURN_BITS) : 6'(REV_BITS);

  // [R01] only 0 and 1 are legal settings
  wire wr_brake = param_wr_i && hit_brake;
  // [R05] manual release refused while the power stage is on
  wire brake_refused = wr_brake && val_manual && power_stage_active_i;
  wire wr_brake_ok = wr_brake && (val_auto || (val_manual && !power_stage_active_i));
  // [R09] standstill required, power stage state ignored
  wire wr_set_ok = param_wr_i && hit_set && standstill_i && abs_captured;
  // readback is read-only, so a write there is an error too
  wire wr_err = param_wr_i && !(wr_brake_ok || wr_set_ok);
  wire rd_err = param_rd_i && !param_wr_i && !hit_any;

  wire [31:0] rd_mux = hit_brake ? {`BRP_HALF_ZERO, brake_release_select} :
                       hit_readback ? abs_readback :
                       hit_set ? abs_set_value : `BRP_WORD_ZERO;

  // ****************************************
  // brake and power stage interlock
  // ****************************************
  wire manual_release = brake_release_select == `BRP_BRAKE_MANUAL;
  // [R02] manual drive only in the two idle states
  wire state_allows = (drive_state_i == brp_sw_on_disabled) ||
                      (drive_state_i == brp_ready_sw_on);
  // [R05] automatic controller owns the brake while powered
  wire next_brake_out = power_stage_active_i ? auto_brake_open_i :
                        (manual_release && state_allows) ? 1'b1 : auto_brake_open_i;
  // [R04] no enable with the brake released by hand
  wire next_enable_grant = enable_request_i && !manual_release;

  // [R03] power stage active forces automatic handling
  wire [15:0] next_brake_release_select = power_stage_active_i ? `BRP_BRAKE_AUTO :
                                          wr_brake_ok ? param_wdata_i[15:0] :
                                          brake_release_select;

  // ****************************************
  // warnings
  // ****************************************
  logic [15:0] next_warn_active;
  logic [15:0] next_warn_latched;

  always_comb begin
    next_warn_active = `BRP_HALF_ZERO;
    // [R08] position not yet captured
    next_warn_active[`BRP_WARN_ABS_BIT] = !abs_captured;
    // a condition still present wins over the clear
    next_warn_latched = (warn_clear_i ? `BRP_HALF_ZERO : warning_latched_word_o) | next_warn_active;
  end

  // ****************************************
  // save hold-off
  // ****************************************
  // the store needs time in non-volatile memory before power may go
  always_comb begin
    next_save_state = save_state;
    next_save_cnt = save_cnt;
    unique case (save_state)
      brp_save_idle: begin
        if (wr_set_ok) begin
          next_save_state = brp_save_hold;
          next_save_cnt = 24'h00_0000;
        end
      end
      brp_save_hold: begin
        if (wr_set_ok) begin
          next_save_cnt = 24'h00_0000;
        end else if (save_cnt == SAVE_LAST) begin
          next_save_state = brp_save_idle;
        end else begin
          next_save_cnt = save_cnt + 24'h00_0001;
        end
      end
    endcase
  end

  // [R10] index shift follows the new position
  wire [31:0] next_index_offset = brp_wrap(param_wdata_i - abs_readback, range_bits);

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      brake_release_select <= `BRP_BRAKE_RESET;
      brake_out_o <= 1'b0;
      brake_error_o <= 1'b0;
      enable_grant_o <= 1'b0;
    end else begin
      brake_release_select <= next_brake_release_select;
      brake_out_o <= next_brake_out;
      brake_error_o <= brake_refused;
      enable_grant_o <= next_enable_grant;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      param_rdata_o <= `BRP_WORD_ZERO;
      param_ack_o <= 1'b0;
      param_err_o <= 1'b0;
    end else begin
      param_rdata_o <= (param_rd_i && !param_wr_i) ? rd_mux : `BRP_WORD_ZERO;
      param_ack_o <= param_wr_i || param_rd_i;
      param_err_o <= wr_err || rd_err;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      warning_active_word_o <= `BRP_HALF_ZERO;
      warning_latched_word_o <= `BRP_HALF_ZERO;
    end else begin
      warning_active_word_o <= next_warn_active;
      warning_latched_word_o <= next_warn_latched;
    end
  end

  // [R12] new value goes to the store, readback waits for power-on
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      abs_set_value <= `BRP_WORD_ZERO;
      abs_store_value_o <= `BRP_WORD_ZERO;
      abs_store_wr_o <= 1'b0;
      index_offset_o <= `BRP_WORD_ZERO;
      esim_index_offset_o <= `BRP_WORD_ZERO;
      index_shift_o <= 1'b0;
    end else begin
      abs_store_wr_o <= wr_set_ok;
      index_shift_o <= wr_set_ok;
      if (wr_set_ok) begin
        abs_set_value <= param_wdata_i;
        abs_store_value_o <= param_wdata_i;
        index_offset_o <= next_index_offset;
        esim_index_offset_o <= next_index_offset;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      save_state <= brp_save_idle;
      save_cnt <= 24'h00_0000;
      abs_store_busy_o <= 1'b0;
    end else begin
      save_state <= next_save_state;
      save_cnt <= next_save_cnt;
      abs_store_busy_o <= next_save_state == brp_save_hold;
    end
  end

endmodule // brp_top

// ---- brp_checker.sv ----
`timescale 1ns/100ps
`include "brp_params.svh"
module brp_checker
  import brp_pkg::*;
(
  // clock, reset and parameter port
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [31:0] param_wdata_i,
  input wire logic param_wr_i,
  input wire logic param_ack_o,
  input wire logic param_err_o,
  // drive and brake
  input wire brp_drive_state_t drive_state_i,
  input wire logic power_stage_active_i,
  input wire logic enable_request_i,
  input wire logic standstill_i,
  input wire logic enable_grant_o,
  input wire logic auto_brake_open_i,
  input wire logic brake_out_o,
  input wire logic brake_error_o,
  // encoder, store and warnings
  input wire logic enc_pos_valid_i,
  input wire logic [31:0] index_offset_o,
  input wire logic [31:0] esim_index_offset_o,
  input wire logic index_shift_o,
  input wire logic [31:0] abs_store_value_o,
  input wire logic abs_store_wr_o,
  input wire logic warn_clear_i,
  input wire logic [15:0] warning_latched_word_o,
  input wire logic [15:0] warning_active_word_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire manual_state = drive_state_i inside {brp_sw_on_disabled, brp_ready_sw_on};
  sequence s_manual_wr;
    param_wr_i && param_addr_i == `BRP_ADDR_BRAKE_RELEASE && param_wdata_i == 32'h0000_0001;
  endsequence
  sequence s_set_wr;
    param_wr_i && param_addr_i == `BRP_ADDR_ABS_SET;
  endsequence
  AST_MAN_GRANT: assert property (s_manual_wr ##0 !power_stage_active_i |=> ##1 !enable_grant_o)
    else $error("grant given with brake released");
  AST_MAN_BRAKE: assert property (s_manual_wr ##0 !power_stage_active_i ##1 manual_state
    |=> brake_out_o)
    else $error("manual release did not open brake");
  AST_BRAKE_STATE: assert property (brake_out_o && !$past(auto_brake_open_i)
    |-> $past(manual_state))
    else $error("manual brake open in wrong state");
  AST_PWR_CLEAR: assert property (power_stage_active_i
    |=> ##1 enable_grant_o == $past(enable_request_i))
    else $error("brake select not cleared by power stage");
  AST_BRAKE_ERR: assert property (s_manual_wr ##0 power_stage_active_i
    |=> brake_error_o && param_err_o)
    else $error("manual release with power on not refused");
  AST_RO: assert property (param_wr_i && param_addr_i == `BRP_ADDR_ABS_READBACK
    |=> param_ack_o && param_err_o)
    else $error("readback write accepted");
  AST_WARN_INIT: assert property ($rose(reset_n_i)
    |=> warning_active_word_o[13] && warning_latched_word_o[13])
    else $error("warning bit missing after reset");
  AST_WARN_PAIR: assert property (warning_active_word_o[13] |-> warning_latched_word_o[13])
    else $error("active warning not latched");
  AST_CAPTURE: assert property ($fell(warning_active_word_o[13]) |-> $past(enc_pos_valid_i, 2))
    else $error("warning cleared without capture");
  AST_WCLR: assert property (warn_clear_i && !warning_active_word_o[13]
    |=> !warning_latched_word_o[13])
    else $error("latched warning not cleared");
  AST_SET: assert property (s_set_wr ##0 standstill_i && !warning_active_word_o[13]
    |=> abs_store_wr_o && index_shift_o && !param_err_o && esim_index_offset_o == index_offset_o
    && abs_store_value_o == $past(param_wdata_i))
    else $error("set position not taken");
  AST_MOVING: assert property (s_set_wr ##0 !standstill_i |=> param_err_o && !abs_store_wr_o)
    else $error("set position accepted while moving");
endmodule // brp_checker

// ---- brp_master_model.sv ----
`timescale 1ns/100ps
module brp_master_model (
  // clock and answer
  input wire logic ref_clk_i,
  input wire logic param_ack_i,
  // request
  output logic [15:0] param_addr_o = 16'h0000,
  output logic [31:0] param_wdata_o = 32'h0000_0000,
  output logic param_wr_o = 1'b0,
  output logic param_rd_o = 1'b0
);
  // strobe is a one-cycle pulse; address and data stay until ack is seen
  task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    param_addr_o <= a;
    param_wdata_o <= d;
    param_wr_o <= w;
    param_rd_o <= !w;
    @(posedge ref_clk_i);
    param_wr_o <= 1'b0;
    param_rd_o <= 1'b0;
    while (param_ack_i !== 1'b1 && n < 8) begin
      @(posedge ref_clk_i);
      n++;
    end
    // released lines never show a stale copy
    param_addr_o <= ~a;
    param_wdata_o <= ~d;
  endtask
endmodule // brp_master_model

// ---- brake_release_abs_position_tb.sv ----
`timescale 1ns/100ps
`include "brp_params.svh"
module brake_release_abs_position_tb;
  import brp_pkg::*;
  localparam int WAIT = 16;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, param_wr_i, param_rd_i, param_ack_o, param_err_o;
  logic [15:0] param_addr_i, warning_latched_word_o, warning_active_word_o;
  logic [31:0] param_wdata_i, param_rdata_o, index_offset_o, esim_index_offset_o;
  logic [31:0] abs_store_value_o, enc_pos_i = 32'h0000_0000, seed = 32'h0000_94CB;
  brp_drive_state_t drive_state_i = brp_sw_on_disabled;
  logic power_stage_active_i = 1'b0, enable_request_i = 1'b1, standstill_i = 1'b1;
  logic auto_brake_open_i = 1'b0, enc_pos_valid_i = 1'b0, enc_multiturn_i = 1'b0;
  logic rotation_direction_invert_i = 1'b0, warn_clear_i = 1'b0;
  logic enable_grant_o, brake_out_o, brake_error_o, index_shift_o, abs_store_wr_o, abs_store_busy_o;
  logic [32:0] rsp_q[$];
  logic [63:0] st_q[$];
  int errors = 0, num_checks = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  brp_top #(.SAVE_WAIT_CYCLES(WAIT)) u_dut (.ref_clk_i, .reset_n_i, .param_addr_i, .param_wdata_i,
    .param_wr_i, .param_rd_i, .param_rdata_o, .param_ack_o, .param_err_o, .drive_state_i,
    .power_stage_active_i, .enable_request_i, .standstill_i, .enable_grant_o, .auto_brake_open_i,
    .brake_out_o, .brake_error_o, .enc_pos_valid_i, .enc_pos_i, .enc_multiturn_i,
    .rotation_direction_invert_i, .index_offset_o, .esim_index_offset_o, .index_shift_o,
    .abs_store_value_o, .abs_store_wr_o, .abs_store_busy_o, .warn_clear_i,
    .warning_latched_word_o, .warning_active_word_o);
  brp_master_model u_master (.ref_clk_i, .param_ack_i(param_ack_o), .param_addr_o(param_addr_i),
    .param_wdata_o(param_wdata_i), .param_wr_o(param_wr_i), .param_rd_o(param_rd_i));
  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e,
    input logic [31:0] r);
    rsp_q.push_back({e, r});
    u_master.access(w, a, d);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one encoder setup from a fresh reset; power stage follows the invert bit
  task automatic run_abs(input logic m, input logic i);
    logic [31:0] mask, rb, np;
    mask = m ? 32'h03FF_FFFF : 32'h0000_3FFF;
    seed = lfsr(seed);
    rb = (i ? -seed : seed) & mask;
    np = lfsr(seed) & mask;
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    enc_pos_valid_i <= 1'b0;
    enc_multiturn_i <= m;
    rotation_direction_invert_i <= i;
    enc_pos_i <= seed;
    power_stage_active_i <= i;
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    acc(1'b0, `BRP_ADDR_ABS_READBACK, 32'h0, 1'b0, `BRP_WORD_ZERO);
    acc(1'b1, `BRP_ADDR_ABS_SET, np, 1'b1, `BRP_WORD_ZERO);
    enc_pos_valid_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    warn_clear_i <= 1'b1;
    standstill_i <= 1'b0;
    acc(1'b1, `BRP_ADDR_ABS_SET, np, 1'b1, `BRP_WORD_ZERO);
    warn_clear_i <= 1'b0;
    standstill_i <= 1'b1;
    st_q.push_back({np, (np - rb) & mask});
    acc(1'b1, `BRP_ADDR_ABS_SET, np, 1'b0, `BRP_WORD_ZERO);
    cmp({63'h0, abs_store_busy_o}, 64'h1);
    acc(1'b0, `BRP_ADDR_ABS_READBACK, 32'h0, 1'b0, rb);
    repeat (WAIT + 4) @(posedge ref_clk_i);
    cmp({63'h0, abs_store_busy_o}, 64'h0);
  endtask
  // ****************************************
  // monitors and sequence
  // ****************************************
  always @(posedge ref_clk_i) begin
    if (param_ack_o === 1'b1) cmp({31'h0, param_err_o, param_rdata_o}, rsp_q.size() ? {31'h0,
      rsp_q.pop_front()} : 'x);
    if (abs_store_wr_o === 1'b1) cmp({abs_store_value_o, index_offset_o}, st_q.size() ?
      st_q.pop_front() : 'x);
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    errors++;
    end_of_test();
  end
  initial begin
    for (int k = 0; k < 4; k++) begin
      run_abs(k[0], k[1]);
    end
    power_stage_active_i <= 1'b0;
    drive_state_i <= brp_ready_sw_on;
    acc(1'b1, `BRP_ADDR_BRAKE_RELEASE, 32'h0000_0001, 1'b0, `BRP_WORD_ZERO);
    acc(1'b0, `BRP_ADDR_BRAKE_RELEASE, 32'h0, 1'b0, 32'h0000_0001);
    acc(1'b1, `BRP_ADDR_BRAKE_RELEASE, 32'h0000_0002, 1'b1, `BRP_WORD_ZERO);
    acc(1'b1, `BRP_ADDR_ABS_READBACK, 32'h0, 1'b1, `BRP_WORD_ZERO);
    acc(1'b0, 16'h0001, 32'h0, 1'b1, `BRP_WORD_ZERO);
    repeat (16) begin
      @(posedge ref_clk_i);
      seed = lfsr(seed);
      drive_state_i <= brp_drive_state_t'(seed[2:0]);
      auto_brake_open_i <= seed[3];
      enable_request_i <= seed[4];
    end
    power_stage_active_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    acc(1'b0, `BRP_ADDR_BRAKE_RELEASE, 32'h0, 1'b0, `BRP_WORD_ZERO);
    acc(1'b1, `BRP_ADDR_BRAKE_RELEASE, 32'h0000_0001, 1'b1, `BRP_WORD_ZERO);
    repeat (4) @(posedge ref_clk_i);
    end_of_test();
  end
endmodule // brake_release_abs_position_tb
bind brp_top brp_checker u_checker (.ref_clk_i, .reset_n_i, .param_addr_i, .param_wdata_i,
  .param_wr_i, .param_ack_o, .param_err_o, .drive_state_i, .power_stage_active_i,
  .enable_request_i, .standstill_i, .enable_grant_o, .auto_brake_open_i, .brake_out_o,
  .brake_error_o, .enc_pos_valid_i, .index_offset_o, .esim_index_offset_o, .index_shift_o,
  .abs_store_value_o, .abs_store_wr_o, .warn_clear_i, .warning_latched_word_o,
  .warning_active_word_o);
